// [core/dmarc_pkg.sv]
// Constants shared by the four-channel request controller: register map, fields and codes.
// Assumes a 32-bit APB register port and a 16-bit data address space.
package dmarc_pkg;

  // ****************************************************************
  // Sizes
  // ****************************************************************
  localparam int NUM_CH    = 4;
  localparam int NUM_SRC   = 256;
  localparam int SEL_W     = 8;
  localparam int ADDR_W    = 16;
  localparam int APB_AW    = 12;
  localparam int CNT_W     = 16;

  // ****************************************************************
  // Register map: one 32-byte window per channel
  // ****************************************************************
  localparam logic [2:0] REG_CTRL  = 3'h0;  // Byte offset 0x00 in window.
  localparam logic [2:0] REG_REQ   = 3'h1;  // Byte offset 0x04, request select.
  localparam logic [2:0] REG_STA   = 3'h2;  // Byte offset 0x08, first start address.
  localparam logic [2:0] REG_STB   = 3'h3;  // Byte offset 0x0C, second start address.
  localparam logic [2:0] REG_PAD   = 3'h4;  // Byte offset 0x10, peripheral address.
  localparam logic [2:0] REG_CNT   = 3'h5;  // Byte offset 0x14, elements per block.
  localparam logic [2:0] REG_STAT  = 3'h6;  // Byte offset 0x18, status (read only).

  // ****************************************************************
  // Control fields
  // ****************************************************************
  localparam int CTL_EN    = 0;
  localparam int CTL_DIR   = 1;  // 1: memory to peripheral.
  localparam int CTL_WORD  = 2;  // 1: 16-bit element.
  localparam int CTL_AM_LO = 3;  // Two-bit addressing mode.
  localparam int CTL_BM_LO = 5;  // Two-bit block mode.
  localparam int CTL_HALF  = 7;  // 1: interrupt at half block.
  localparam int CTL_SOFT  = 8;  // Write 1 to start one element.
  localparam int CTL_W     = 8;  // Stored control bits [7:0].

  localparam logic [1:0] AM_POSTINC = 2'h0;
  localparam logic [1:0] AM_FIXED   = 2'h1;
  localparam logic [1:0] AM_PERIPH  = 2'h2;

  localparam int BM_REPEAT = 0;  // Bit in block mode field.
  localparam int BM_PPONG  = 1;  // Bit in block mode field.

  localparam logic [SEL_W-1:0] SRC_EXT_EXTERNAL_INTERRUPT_ZERO = 8'h00;  // Code for external_interrupt_zero.
  localparam logic [CTL_W-1:0] CTRL_RST     = 8'h00;
  localparam logic [CNT_W-1:0] CNT_RST      = 16'h0001;

endpackage : dmarc_pkg

// [core/dmarc_top.sv]
// Four-channel direct memory access request controller with an APB register port.
// Assumes peripheral request pulses and the element mover run on pclk.
//
// What this block does
// (R1) Timer and external interrupts trigger channel moves.
// (R2) Each channel moves data one direction only.
// (R3) Software uses two channels for both directions.
// (R4) Fixed channel-number priority; losers stay pending.
// (R5) Block finish raises an interrupt to CPU.
// (R6) Interrupt at half or full block, selectable.
// (R7) Element size is byte or word.
// (R8) Post-increment mode advances address per element.
// (R9) Fixed mode keeps memory address constant.
// (R10) Peripheral-indirect mode uses peripheral-supplied address.
// (R11) Start by software write or peripheral request.
// (R12) One-shot stops; auto-repeat restarts block.
// (R13) Ping-pong alternates two start addresses per block.
// (R14) Eight-bit source select; zero is external interrupt.
// (R15) Input capture two uses its buffer address.
// (R16) Output compare one targets compare registers.
// (R17) First serial receiver uses receive register.
// (R18) First serial transmitter uses transmit register.
// (R19) CAN receive uses receive data address.
// (R20) CAN transmit uses transmit data address.
// (R21) Analog converter uses first result buffer.
// (R22) Lowest channel number wins among pending.
`timescale 1ns/1ps
`default_nettype none

module dmarc_top
  import dmarc_pkg::*;
#(
  parameter int NCH  = dmarc_pkg::NUM_CH,
  parameter int NSRC = dmarc_pkg::NUM_SRC
) (
  input  wire logic                         pclk,
  input  wire logic                         presetn,
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [dmarc_pkg::APB_AW-1:0] paddr,
  input  wire logic [31:0]                  pwdata,
  output logic      [31:0]                  prdata,
  output logic                              pready,
  output logic                              pslverr,
  input  wire logic [NSRC-1:0]              src_req,
  input  wire logic [dmarc_pkg::ADDR_W-1:0] periph_mem_addr,
  output logic                              xfer_valid,
  input  wire logic                         xfer_ready,
  output logic [$clog2(NCH)-1:0]            xfer_chan,
  output logic                              xfer_to_periph,
  output logic                              xfer_word,
  output logic [dmarc_pkg::ADDR_W-1:0]      xfer_mem_addr,
  output logic [dmarc_pkg::ADDR_W-1:0]      xfer_periph_addr,
  output logic [NCH-1:0]                    block_irq
);
  import dmarc_pkg::*;

  localparam int CHW = $clog2(NCH);

  // ****************************************************************
  // Helpers
  // ****************************************************************

  // Picks the lowest-numbered set bit; channel 0 has the highest priority.
  function automatic logic [CHW-1:0] dmarc_lowest(input logic [NCH-1:0] v);
    logic [CHW-1:0] idx;
    idx = '0;
    for (int i = NCH - 1; i >= 0; i--) begin
      if (v[i]) begin
        idx = CHW'(i);
      end
    end
    return idx;
  endfunction : dmarc_lowest

  // ****************************************************************
  // State
  // ****************************************************************
  logic [CTL_W-1:0]  ctrl_ff [NCH];
  logic [CTL_W-1:0]  nxt_ctrl [NCH];
  logic [SEL_W-1:0]  rsel_ff [NCH];
  logic [SEL_W-1:0]  nxt_rsel [NCH];
  logic [ADDR_W-1:0] sta_ff [NCH];
  logic [ADDR_W-1:0] nxt_sta [NCH];
  logic [ADDR_W-1:0] stb_ff [NCH];
  logic [ADDR_W-1:0] nxt_stb [NCH];
  logic [ADDR_W-1:0] pad_ff [NCH];
  logic [ADDR_W-1:0] nxt_pad [NCH];
  logic [CNT_W-1:0]  cnt_ff [NCH];
  logic [CNT_W-1:0]  nxt_cnt [NCH];
  logic [CNT_W-1:0]  done_ff [NCH];
  logic [CNT_W-1:0]  nxt_done [NCH];
  logic [ADDR_W-1:0] offs_ff [NCH];
  logic [ADDR_W-1:0] nxt_offs [NCH];
  logic [NCH-1:0]    pend_ff;
  logic [NCH-1:0]    nxt_pend;
  logic [NCH-1:0]    pp_ff;
  logic [NCH-1:0]    nxt_pp;
  logic [NCH-1:0]    irq_ff;
  logic [NCH-1:0]    nxt_irq;
  logic [NSRC-1:0]   src_prev_ff;
  logic              busy_ff;
  logic              nxt_busy;
  logic [CHW-1:0]    gch_ff;
  logic [CHW-1:0]    nxt_gch;
  logic              dir_ff;
  logic              nxt_dir;
  logic              word_ff;
  logic              nxt_word;
  logic [ADDR_W-1:0] maddr_ff;
  logic [ADDR_W-1:0] nxt_maddr;
  logic [ADDR_W-1:0] paddr_ff;
  logic [ADDR_W-1:0] nxt_paddr;
  logic [31:0]       rdata_ff;
  logic [31:0]       nxt_rdata;

  logic              win_ok;
  logic [CHW-1:0]    win_ch;
  logic [2:0]        win_reg;
  logic              wr_en;
  logic              done_evt;
  logic [NCH-1:0]    ready_ch;
  logic [CHW-1:0]    pick;

  // ****************************************************************
  // APB decode
  // ****************************************************************

  // Each channel owns a 32-byte window starting at channel times 0x20.
  always_comb begin
    win_ch  = paddr[5 +: CHW];
    win_reg = paddr[4:2];
    win_ok  = (paddr[APB_AW-1:5] < (APB_AW-5)'(NCH)) && (paddr[1:0] == 2'h0)
              && (win_reg <= REG_STAT);
  end

  // The port never inserts wait states; an error shows only in the access phase.
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~win_ok;
  assign prdata  = rdata_ff;
  assign wr_en   = psel & penable & pwrite & win_ok;

  // Read data is captured during the setup cycle so the access phase needs no wait.
  always_comb begin
    nxt_rdata = rdata_ff;
    if (psel && !penable) begin
      nxt_rdata = 32'h0000_0000;
      if (win_ok && !pwrite) begin
        case (win_reg)
          REG_CTRL: nxt_rdata = {24'h00_0000, ctrl_ff[win_ch]};
          REG_REQ:  nxt_rdata = {24'h00_0000, rsel_ff[win_ch]};
          REG_STA:  nxt_rdata = {16'h0000, sta_ff[win_ch]};
          REG_STB:  nxt_rdata = {16'h0000, stb_ff[win_ch]};
          REG_PAD:  nxt_rdata = {16'h0000, pad_ff[win_ch]};
          REG_CNT:  nxt_rdata = {16'h0000, cnt_ff[win_ch]};
          REG_STAT: nxt_rdata = {done_ff[win_ch], 13'h0000, pp_ff[win_ch],
                                 busy_ff && (gch_ff == win_ch), pend_ff[win_ch]};
          default:  nxt_rdata = 32'h0000_0000;
        endcase
      end
    end
  end

  // ****************************************************************
  // Channel registers, request capture and block sequencing
  // ****************************************************************

  // An element completes at the edge where the mover accepts it.
  assign done_evt = busy_ff & xfer_ready;

  // Per-channel next state; hardware clears come first so that a set wins over them, and a software disable comes last and wins over any set.
  always_comb begin
    nxt_pend = pend_ff;
    nxt_pp   = pp_ff;
    nxt_irq  = '0;
    for (int c = 0; c < NCH; c++) begin
      nxt_ctrl[c] = ctrl_ff[c];
      nxt_rsel[c] = rsel_ff[c];
      nxt_sta[c]  = sta_ff[c];
      nxt_stb[c]  = stb_ff[c];
      nxt_pad[c]  = pad_ff[c];
      nxt_cnt[c]  = cnt_ff[c];
      nxt_done[c] = done_ff[c];
      nxt_offs[c] = offs_ff[c];
      // Completion of one element updates count, address and block mode.
      if (done_evt && (gch_ff == CHW'(c))) begin
        nxt_pend[c] = 1'b0;
        nxt_done[c] = done_ff[c] + 16'h0001;
        if (ctrl_ff[c][CTL_AM_LO +: 2] == AM_POSTINC) begin  // R8
          nxt_offs[c] = offs_ff[c] + (ctrl_ff[c][CTL_WORD] ? 16'h0002 : 16'h0001);  // R7
        end else begin
          nxt_offs[c] = offs_ff[c];  // R9
        end
        if (ctrl_ff[c][CTL_HALF] && (nxt_done[c] == (cnt_ff[c] >> 1))) begin
          nxt_irq[c] = 1'b1;  // R6
        end
        if (nxt_done[c] >= cnt_ff[c]) begin
          nxt_done[c] = 16'h0000;
          nxt_offs[c] = 16'h0000;
          nxt_irq[c]  = ~ctrl_ff[c][CTL_HALF];  // R5 R6
          if (ctrl_ff[c][CTL_BM_LO + BM_PPONG]) begin
            nxt_pp[c] = ~pp_ff[c];  // R13
          end
          if (!ctrl_ff[c][CTL_BM_LO + BM_REPEAT]) begin
            nxt_ctrl[c][CTL_EN] = 1'b0;  // R12
          end
        end
      end
      // A selected source edge queues one element for an enabled channel.
      if (ctrl_ff[c][CTL_EN] && src_req[rsel_ff[c]] && !src_prev_ff[rsel_ff[c]]) begin
        nxt_pend[c] = 1'b1;  // R1 R11 R14
      end
      // Software writes: configuration and a one-element manual start.
      if (wr_en && (win_ch == CHW'(c))) begin
        case (win_reg)
          REG_CTRL: begin
            nxt_ctrl[c] = pwdata[CTL_W-1:0];
            if (pwdata[CTL_SOFT] && pwdata[CTL_EN]) begin
              nxt_pend[c] = 1'b1;  // R11
            end
            if (!pwdata[CTL_EN]) begin
              nxt_done[c] = 16'h0000;
              nxt_offs[c] = 16'h0000;
              nxt_pp[c]   = 1'b0;
              // A disabled channel drops its queued element so a later enable starts clean.
              nxt_pend[c] = 1'b0;
            end
          end
          REG_REQ:  nxt_rsel[c] = pwdata[SEL_W-1:0];
          REG_STA:  nxt_sta[c]  = pwdata[ADDR_W-1:0];
          REG_STB:  nxt_stb[c]  = pwdata[ADDR_W-1:0];
          REG_PAD:  nxt_pad[c]  = pwdata[ADDR_W-1:0];
          REG_CNT:  nxt_cnt[c]  = pwdata[CNT_W-1:0];
          default:  nxt_cnt[c]  = cnt_ff[c];
        endcase
      end
    end
  end

  // ****************************************************************
  // Arbitration and element issue
  // ****************************************************************

  // Only enabled channels with a queued element take part in arbitration.
  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      ready_ch[c] = pend_ff[c] & ctrl_ff[c][CTL_EN];
    end
    pick = dmarc_lowest(ready_ch);  // R4 R22
  end

  // One element is in flight at a time; losers keep their pending flag.
  always_comb begin
    nxt_busy  = busy_ff;
    nxt_gch   = gch_ff;
    nxt_dir   = dir_ff;
    nxt_word  = word_ff;
    nxt_maddr = maddr_ff;
    nxt_paddr = paddr_ff;
    if (done_evt) begin
      nxt_busy = 1'b0;
    end else if (!busy_ff && (ready_ch != '0)) begin
      nxt_busy  = 1'b1;  // R4
      nxt_gch   = pick;
      nxt_dir   = ctrl_ff[pick][CTL_DIR];  // R2
      nxt_word  = ctrl_ff[pick][CTL_WORD];  // R7
      nxt_paddr = pad_ff[pick];
      if (ctrl_ff[pick][CTL_AM_LO +: 2] == AM_PERIPH) begin
        nxt_maddr = periph_mem_addr;  // R10
      end else begin
        // The sum wraps inside the 16-bit space; a block must not cross the top.
        nxt_maddr = (pp_ff[pick] ? stb_ff[pick] : sta_ff[pick]) + offs_ff[pick];  // R13
      end
    end
  end

  // Element outputs come from registers, so they stay stable while an element waits.
  assign xfer_valid       = busy_ff;
  assign xfer_chan        = gch_ff;
  assign xfer_to_periph   = dir_ff;
  assign xfer_word        = word_ff;
  assign xfer_mem_addr    = maddr_ff;
  assign xfer_periph_addr = paddr_ff;
  assign block_irq        = irq_ff;

  // ****************************************************************
  // Registers
  // ****************************************************************

  // All state registers of the controller.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int c = 0; c < NCH; c++) begin
        ctrl_ff[c] <= CTRL_RST;
        rsel_ff[c] <= SRC_EXT_EXTERNAL_INTERRUPT_ZERO;
        sta_ff[c]  <= '0;
        stb_ff[c]  <= '0;
        pad_ff[c]  <= '0;
        cnt_ff[c]  <= CNT_RST;
        done_ff[c] <= '0;
        offs_ff[c] <= '0;
      end
      pend_ff     <= '0;
      pp_ff       <= '0;
      irq_ff      <= '0;
      src_prev_ff <= '0;
      busy_ff     <= 1'b0;
      gch_ff      <= '0;
      dir_ff      <= 1'b0;
      word_ff     <= 1'b0;
      maddr_ff    <= '0;
      paddr_ff    <= '0;
      rdata_ff    <= 32'h0000_0000;
    end else begin
      for (int c = 0; c < NCH; c++) begin
        ctrl_ff[c] <= nxt_ctrl[c];
        rsel_ff[c] <= nxt_rsel[c];
        sta_ff[c]  <= nxt_sta[c];
        stb_ff[c]  <= nxt_stb[c];
        pad_ff[c]  <= nxt_pad[c];
        cnt_ff[c]  <= nxt_cnt[c];
        done_ff[c] <= nxt_done[c];
        offs_ff[c] <= nxt_offs[c];
      end
      pend_ff     <= nxt_pend;
      pp_ff       <= nxt_pp;
      irq_ff      <= nxt_irq;
      src_prev_ff <= src_req;
      busy_ff     <= nxt_busy;
      gch_ff      <= nxt_gch;
      dir_ff      <= nxt_dir;
      word_ff     <= nxt_word;
      maddr_ff    <= nxt_maddr;
      paddr_ff    <= nxt_paddr;
      rdata_ff    <= nxt_rdata;
    end
  end

endmodule : dmarc_top

`default_nettype wire

// [verification/dmarc_mover_model.sv]
// Element mover stand-in: completes each element after a set number of wait cycles.
// Assumes the controller holds an element request until the edge that completes it.
`timescale 1ns/1ps
`default_nettype none

module dmarc_mover_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        xfer_valid,
  input  wire logic [3:0]  stall,
  input  wire logic [15:0] pm_addr,
  output logic             xfer_ready,
  output logic [15:0]      periph_mem_addr
);
  logic [3:0] wait_ff;
  logic [3:0] nxt_wait;

  // ****************************************************************
  // Wait counter
  // ****************************************************************
  // Counts the wait cycles of the element in flight and restarts after each completion.
  always_comb begin
    nxt_wait = (xfer_valid && !xfer_ready) ? wait_ff + 4'h1 : 4'h0;
  end

  // Registers the wait count.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_ff <= 4'h0;
    end else begin
      wait_ff <= nxt_wait;
    end
  end

  // Completion comes only while a request stands, so a slow mover is modelled too.
  assign xfer_ready = xfer_valid && (wait_ff == stall);
  // The requesting peripheral supplies its own memory address.
  assign periph_mem_addr = pm_addr;
endmodule : dmarc_mover_model

`default_nettype wire

// [verification/dmarc_top_monitor.sv]
// Checker for the element port and completion pulses of the request controller.
// Assumes it is bound to the controller top and sees only its ports.
`timescale 1ns/1ps
`default_nettype none

module dmarc_top_monitor #(
  parameter int NCH  = 4,
  parameter int NSRC = 256
) (
  input wire logic                   pclk,
  input wire logic                   presetn,
  input wire logic                   xfer_valid,
  input wire logic                   xfer_ready,
  input wire logic [$clog2(NCH)-1:0] xfer_chan,
  input wire logic                   xfer_to_periph,
  input wire logic                   xfer_word,
  input wire logic [15:0]            xfer_mem_addr,
  input wire logic [NCH-1:0]         block_irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ****************************************************************
  // Properties
  // ****************************************************************
  // A waiting element keeps its request, direction and size.
  property p_hold_dir;
    xfer_valid && !xfer_ready |=> xfer_valid && $stable(xfer_to_periph);
  endproperty
  property p_hold_word;
    xfer_valid && !xfer_ready |=> $stable(xfer_word) && $stable(xfer_mem_addr);
  endproperty
  property p_hold_chan;
    xfer_valid && !xfer_ready |=> $stable(xfer_chan);
  endproperty
  // One element at a time, with a gap of at least one cycle after each.
  property p_gap;
    xfer_valid && xfer_ready |=> !xfer_valid;
  endproperty
  property p_drop;
    $fell(xfer_valid) |-> $past(xfer_ready);
  endproperty
  // Completion pulses follow a completed element of the same channel and last one cycle.
  property p_irq_cause;
    |block_irq |-> $past(xfer_valid && xfer_ready);
  endproperty
  property p_irq_chan;
    |block_irq |-> block_irq == (NCH'(1) << $past(xfer_chan));
  endproperty
  property p_irq_pulse;
    |block_irq |=> block_irq == '0;
  endproperty

  a_hold_dir: assert property (p_hold_dir) else $error("direction moved while waiting");
  a_hold_word: assert property (p_hold_word) else $error("size or address moved");
  a_hold_chan: assert property (p_hold_chan) else $error("channel moved while waiting");
  a_gap: assert property (p_gap) else $error("request not dropped after completion");
  a_drop: assert property (p_drop) else $error("request dropped without completion");
  a_irq_cause: assert property (p_irq_cause) else $error("pulse without completion");
  a_irq_chan: assert property (p_irq_chan) else $error("pulse on wrong channel");
  a_irq_pulse: assert property (p_irq_pulse) else $error("pulse longer than one cycle");

  c_stall: cover property (xfer_valid && !xfer_ready ##1 xfer_ready);
  c_irq_low: cover property (block_irq[0]);
  c_irq_high: cover property (block_irq[NCH-1]);
endmodule : dmarc_top_monitor

bind dmarc_top dmarc_top_monitor #(.NCH(NCH), .NSRC(NSRC)) dmarc_top_monitor_i (
  .pclk(pclk), .presetn(presetn), .xfer_valid(xfer_valid), .xfer_ready(xfer_ready),
  .xfer_chan(xfer_chan), .xfer_to_periph(xfer_to_periph), .xfer_word(xfer_word),
  .xfer_mem_addr(xfer_mem_addr), .block_irq(block_irq));

`default_nettype wire

// [verification/dmarc_top_tb.sv]
// Self-checking bench for the request controller: APB master, scenarios and verdict.
// Assumes the mover model completes elements and supplies peripheral addresses.
`timescale 1ns/1ps
`default_nettype none

module dmarc_top_tb;
  import dmarc_pkg::*;
  logic         pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0]  paddr = 12'h000;
  logic [31:0]  pwdata = 32'h0, prdata, rd;
  logic         pready, pslverr, slv, xfer_valid, xfer_ready, xfer_to_periph, xfer_word;
  logic [255:0] src_req = '0;
  logic [15:0]  periph_mem_addr, xfer_mem_addr, xfer_periph_addr, pm_addr = 16'h0000;
  logic [1:0]   xfer_chan;
  logic [3:0]   block_irq, stall = 4'h0;
  int           err_total = 0, checks = 0, cyc = 0;

  dmarc_top dmarc_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .src_req(src_req), .periph_mem_addr(periph_mem_addr),
    .xfer_valid(xfer_valid), .xfer_ready(xfer_ready), .xfer_chan(xfer_chan),
    .xfer_to_periph(xfer_to_periph), .xfer_word(xfer_word), .xfer_mem_addr(xfer_mem_addr),
    .xfer_periph_addr(xfer_periph_addr), .block_irq(block_irq));
  dmarc_mover_model dmarc_mover_model_i (.pclk(pclk), .presetn(presetn),
    .xfer_valid(xfer_valid), .stall(stall), .pm_addr(pm_addr), .xfer_ready(xfer_ready),
    .periph_mem_addr(periph_mem_addr));

  // ****************************************************************
  // Clock, timeout and shared tasks
  // ****************************************************************
  // The clock toggles every half period of 20 ns.
  always #20 pclk = ~pclk;

  // A hang is cut short after far more cycles than the scenarios need.
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : chk

  // One APB transfer; read data and error are taken at the edge that samples pready.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input int ch, input logic [2:0] r, input logic [31:0] d);
    apb(1'b1, 12'(ch * 32) + {7'h00, r, 2'h0}, d);
  endtask : wr

  // Raises the given requests, waits for one completed element and judges it.
  task automatic elem(input logic [255:0] req, input logic [1:0] ch, input logic [15:0] ma,
                      input logic [3:0] irq, input logic [17:0] wdp);
    int n;
    @(posedge pclk);
    src_req <= req;
    n = 0;
    do begin
      @(negedge pclk);
      n++;
    end while (!(xfer_valid === 1'b1 && xfer_ready === 1'b1) && n < 40);
    chk(32'(xfer_valid & xfer_ready), 32'h1);
    chk(32'({xfer_chan, xfer_mem_addr}), 32'({ch, ma}));
    chk(32'({xfer_word, xfer_to_periph, xfer_periph_addr}), 32'(wdp));
    @(posedge pclk);
    src_req <= '0;
    @(negedge pclk);
    chk(32'(block_irq), 32'(irq));
  endtask : elem

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  // Reset values and an unmapped access.
  task automatic t_reset();
    apb(1'b0, 12'h004, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 12'h0FC, 32'h0);
    chk(32'({pready, slv}), 32'h3);
    chk(rd, 32'h0);
  endtask : t_reset

  // Every listed source code triggers channel 0, with its peripheral address and direction.
  task automatic t_codes();
    logic [7:0]  code [9] = '{8'h00, 8'h05, 8'h02, 8'h0B, 8'h0C, 8'h22, 8'h46, 8'h0D, 8'h07};
    logic [15:0] pad [9] = '{16'h0, 16'h014C, 16'h0906, 16'h0226, 16'h0224, 16'h0440,
                             16'h0442, 16'h0300, 16'h0};
    logic        dir [9] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
    wr(0, REG_STA, 32'h0040);
    for (int i = 0; i < 9; i++) begin
      wr(0, REG_REQ, 32'(code[i]));
      wr(0, REG_PAD, 32'(pad[i]));
      wr(0, REG_CTRL, 32'h29 | 32'({dir[i], 1'b0}));
      elem(256'(1) << code[i], 2'd0, 16'h0040, 4'h1, {1'b0, dir[i], pad[i]});
    end
    wr(0, REG_CTRL, 32'h0);
  endtask : t_codes

  // Word elements step by two; a one-shot block clears enable and ignores later requests.
  task automatic t_oneshot();
    wr(1, REG_STA, 32'h0100);
    wr(1, REG_CNT, 32'h3);
    wr(1, REG_REQ, 32'h10);
    wr(1, REG_CTRL, 32'h105);
    elem('0, 2'd1, 16'h0100, 4'h0, 18'h20000);
    elem(256'(1) << 8'h10, 2'd1, 16'h0102, 4'h0, 18'h20000);
    elem(256'(1) << 8'h10, 2'd1, 16'h0104, 4'h2, 18'h20000);
    apb(1'b0, 12'h020, 32'h0);
    chk(rd, 32'h04);
    @(posedge pclk);
    src_req[8'h10] <= 1'b1;
    @(posedge pclk);
    src_req <= '0;
    repeat (4) @(negedge pclk);
    chk(32'(xfer_valid), 32'h0);
  endtask : t_oneshot

  // Two channels requested at once: the lower number goes first, the other stays pending.
  task automatic t_prio();
    wr(1, REG_CNT, 32'h1);
    wr(1, REG_STA, 32'h0300);
    wr(1, REG_REQ, 32'h21);
    wr(1, REG_CTRL, 32'h09);
    wr(2, REG_CNT, 32'h2);
    wr(2, REG_STA, 32'h0200);
    wr(2, REG_REQ, 32'h20);
    wr(2, REG_CTRL, 32'h09);
    stall <= 4'h6;
    elem((256'(1) << 8'h20) | (256'(1) << 8'h21), 2'd1, 16'h0300, 4'h2, 18'h0);
    elem('0, 2'd2, 16'h0200, 4'h0, 18'h0);
    stall <= 4'h1;
    elem(256'(1) << 8'h20, 2'd2, 16'h0200, 4'h4, 18'h0);
  endtask : t_prio

  // Peripheral-supplied addresses, with the pulse at the half-block point only.
  task automatic t_half();
    wr(2, REG_CNT, 32'h4);
    wr(2, REG_CTRL, 32'h91);
    for (int k = 0; k < 4; k++) begin
      @(posedge pclk);
      pm_addr <= 16'h0AB0 + 16'(k);
      elem(256'(1) << 8'h20, 2'd2, 16'h0AB0 + 16'(k), (k == 1) ? 4'h4 : 4'h0, 18'h0);
    end
  endtask : t_half

  // Ping-pong blocks alternate between the two start addresses and keep running.
  task automatic t_pingpong();
    wr(3, REG_STA, 32'h0400);
    wr(3, REG_STB, 32'h0500);
    wr(3, REG_REQ, 32'h30);
    wr(3, REG_CTRL, 32'h61);
    for (int k = 0; k < 3; k++) begin
      elem(256'(1) << 8'h30, 2'd3, k[0] ? 16'h0500 : 16'h0400, 4'h8, 18'h0);
    end
    apb(1'b0, 12'h078, 32'h0);
    chk(rd, 32'h4);
  endtask : t_pingpong

  // Main sequence.
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_codes();
    t_oneshot();
    t_prio();
    t_half();
    t_pingpong();
    end_of_test();
  end
endmodule : dmarc_top_tb

`default_nettype wire
